// ### rtl/prot_pkg.sv
// constants for the charger input protection sequencer
// assumes a 100 MHz internal clock
package prot_pkg;
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned SETTLE_US          = 10;
  localparam int unsigned OV_REC_US          = 10;
  localparam int unsigned OC_BLANK_US        = 5;
  localparam int unsigned OC_OFF_US          = 20;
  localparam int unsigned SOFT_RAMP_US       = 2;
  localparam int unsigned SETTLE_CYC         = SETTLE_US * CLK_MHZ;
  localparam int unsigned OV_REC_CYC         = OV_REC_US * CLK_MHZ;
  localparam int unsigned OC_BLANK_CYC       = OC_BLANK_US * CLK_MHZ;
  localparam int unsigned OC_OFF_CYC         = OC_OFF_US * CLK_MHZ;
  localparam int unsigned SOFT_RAMP_CYC      = SOFT_RAMP_US * CLK_MHZ;
  localparam int unsigned TMR_W              = 16;
  localparam int unsigned EVT_W              = 4;
  localparam logic [3:0]  EVT_LIMIT          = 4'hF;
  localparam logic [3:0]  EVT_RESET          = 4'h0;
  localparam int unsigned SYNC_W             = 5;
  localparam int unsigned GATE_W             = 8;
  localparam logic [7:0]  GATE_FULL          = 8'hFF;
  localparam logic [7:0]  GATE_OFF           = 8'h00;
  // gray coded along power-up path
  typedef enum logic [2:0] {
    ST_DOWN   = 3'b000,
    ST_SETTLE = 3'b001,
    ST_ON     = 3'b011,
    ST_BLANK  = 3'b010,
    ST_PROT   = 3'b110,
    ST_LOCK   = 3'b111,
    ST_DIS    = 3'b101
  } seq_state_t;
endpackage

// ### rtl/flag_sync.sv
// two-stage synchroniser bank for comparator flags
// assumes flags are level signals
`timescale 1ns/1ps
`default_nettype none
module flag_sync
  import prot_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic [SYNC_W-1:0] i_async,
  output logic      [SYNC_W-1:0] o_sync
);
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++)
    begin : g_bit
      always_ff @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end
        else
        begin
          meta_r[g] <= i_async[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate
  assign o_sync = sync_r;
endmodule
`default_nettype wire

// ### rtl/charger_input_protection_fsm.sv
// protection sequencer: pass switch gate, fault timers, event counters
// assumes i_rstn is the undervoltage lockout power-on reset, comparators external
// Behaviour
// - below lockout: switch off, alert released
// - lockout release resets counters and state
// - wait settle, switch on if safe
// - switch on with soft-start ramp
// - overvolt at settle end: stay off until overvolt clears and recovery delay ends
// - overvolt: switch off fast, alert low
// - overvolt clears: on after recovery delay
// - overcurrent: limit and start blank timer
// - blank expires: off for off-time, retry
// - fifteen overcurrent trips latch switch off
// - enable cycle or power cycle clears counters
// - overcurrent shutdown uses soft-stop
// - battery overvolt: switch off, alert low
// - battery below hysteresis: switch back on
// - fifteen battery overvolt events latch off
// - battery overvolt uses soft-stop
// - overtemperature: off, back on below release
// - enable high turns switch off
// - undriven enable defaults to enabled
// - alert released when safe or disabled
// - enabled: alert low on any fault, but only on hard faults during settle
// - enable input is active low
// - alert is open-drain, pulls low only
`timescale 1ns/1ps
`default_nettype none
module charger_input_protection_fsm
  import prot_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_input_overvolt,
  input  wire logic              i_overcurrent,
  input  wire logic              i_battery_overvolt,
  input  wire logic              i_overtemp,
  input  wire logic              i_chip_en_n,
  output logic                   o_pass_switch_on,
  output logic      [GATE_W-1:0] o_pass_switch_gate,
  output logic                   o_soft_start,
  output logic                   o_soft_stop,
  output logic                   o_current_limit,
  output logic                   o_alert_n_out,
  output logic                   o_alert_n_oe,
  output logic      [EVT_W-1:0]  o_oc_count,
  output logic      [EVT_W-1:0]  o_bov_count
);
  // ****************************************
  // input synchronisation
  // ****************************************
  logic [SYNC_W-1:0] flags_s;
  logic              ovp;
  logic              overcurrent_trip;
  logic              bov;
  logic              otp;
  logic              dis;

  flag_sync u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async ({i_chip_en_n, i_overtemp, i_battery_overvolt, i_overcurrent,
               i_input_overvolt}),
    .o_sync  (flags_s)
  );

  assign ovp = flags_s[0];
  assign overcurrent_trip = flags_s[1];
  assign bov = flags_s[2];
  assign otp = flags_s[3];
  // floating pin pulled down externally, so low means enabled
  assign dis = flags_s[4];

  // ****************************************
  // state registers
  // ****************************************
  seq_state_t        state_r;
  seq_state_t        state_nxt;
  logic [TMR_W-1:0]  tmr_r;
  logic [TMR_W-1:0]  tmr_nxt;
  logic [EVT_W-1:0]  oc_cnt_r;
  logic [EVT_W-1:0]  oc_cnt_nxt;
  logic [EVT_W-1:0]  bov_cnt_r;
  logic [EVT_W-1:0]  bov_cnt_nxt;
  logic              bov_prev_r;
  logic              ovp_seen_r;
  logic              ovp_seen_nxt;
  logic              oc_trip_r;
  logic              oc_trip_nxt;
  logic [GATE_W-1:0] gate_r;
  logic [GATE_W-1:0] gate_nxt;
  logic              alert_r;
  logic              cl_r;
  logic [1:0]        ramp_div_r;

  // ****************************************
  // decode
  // ****************************************
  logic tmr_done;
  logic bov_rise;
  logic hard_fault;
  logic oc_full;
  logic bov_full;
  logic any_fault;
  logic latched;
  logic want_on;
  logic fast_off;
  logic soft_off;
  logic gate_step;
  logic alert_nxt;

  assign tmr_done   = (tmr_r == '0);
  assign bov_rise   = bov && !bov_prev_r;
  assign hard_fault = ovp || bov || otp;
  assign oc_full    = (oc_cnt_r == EVT_LIMIT);
  assign bov_full   = (bov_cnt_r == EVT_LIMIT);
  assign latched    = oc_full || bov_full;
  assign any_fault  = hard_fault || overcurrent_trip || latched
                      || (state_r == ST_PROT && (ovp_seen_r || oc_trip_r));
  assign want_on    = (state_r == ST_ON) || (state_r == ST_BLANK);
  // overvoltage and temperature cut the gate at once, battery and current ramp
  assign fast_off   = ovp || otp || dis || (state_r == ST_DOWN);
  assign soft_off   = !want_on && !fast_off;
  // free prescaler, so a held fault timer never stalls the ramp
  assign gate_step  = (ramp_div_r == 2'b00);
  assign alert_nxt  = !dis && (state_r != ST_DOWN) && (state_r != ST_SETTLE || hard_fault)
                      && (any_fault || state_r == ST_LOCK);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    state_nxt    = state_r;
    tmr_nxt      = tmr_done ? tmr_r : tmr_r - 1'b1;
    oc_cnt_nxt   = oc_cnt_r;
    bov_cnt_nxt  = bov_cnt_r;
    ovp_seen_nxt = ovp_seen_r;
    oc_trip_nxt  = oc_trip_r;
    if (bov_rise && !dis && !bov_full && state_r != ST_DOWN && state_r != ST_SETTLE)
      bov_cnt_nxt = bov_cnt_r + 1'b1;
    case (state_r)
      ST_DOWN:
      begin
        state_nxt = ST_SETTLE;
        tmr_nxt   = TMR_W'(SETTLE_CYC);
      end
      ST_SETTLE:
      begin
        if (tmr_done)
        begin
          if (ovp)
          begin
            state_nxt    = ST_PROT;
            ovp_seen_nxt = 1'b1;
            tmr_nxt      = TMR_W'(OV_REC_CYC);
          end
          else if (dis)
            state_nxt = ST_DIS;
          else if (!bov && !otp)
            state_nxt = ST_ON;
        end
      end
      ST_ON:
      begin
        if (dis)
          state_nxt = ST_DIS;
        else if (latched)
          state_nxt = ST_LOCK;
        else if (hard_fault)
        begin
          state_nxt    = ST_PROT;
          ovp_seen_nxt = ovp;
          oc_trip_nxt  = 1'b0;
          tmr_nxt      = TMR_W'(OV_REC_CYC);
        end
        else if (overcurrent_trip)
        begin
          state_nxt = ST_BLANK;
          tmr_nxt   = TMR_W'(OC_BLANK_CYC);
        end
      end
      ST_BLANK:
      begin
        if (dis)
          state_nxt = ST_DIS;
        else if (hard_fault)
        begin
          state_nxt    = ST_PROT;
          ovp_seen_nxt = ovp;
          oc_trip_nxt  = 1'b0;
          tmr_nxt      = TMR_W'(OV_REC_CYC);
        end
        else if (!overcurrent_trip)
          state_nxt = ST_ON;
        else if (tmr_done)
        begin
          state_nxt   = ST_PROT;
          oc_trip_nxt = 1'b1;
          tmr_nxt     = TMR_W'(OC_OFF_CYC);
          oc_cnt_nxt  = oc_cnt_r + 1'b1;
        end
      end
      ST_PROT:
      begin
        if (dis)
          state_nxt = ST_DIS;
        else if (latched)
          state_nxt = ST_LOCK;
        else if (ovp)
        begin
          ovp_seen_nxt = 1'b1;
          tmr_nxt      = TMR_W'(OV_REC_CYC);
        end
        else if (bov || otp)
          tmr_nxt = tmr_r;
        else if (tmr_done || (!ovp_seen_r && !oc_trip_r))
        begin
          state_nxt    = ST_ON;
          ovp_seen_nxt = 1'b0;
          oc_trip_nxt  = 1'b0;
        end
      end
      ST_LOCK:
      begin
        if (dis)
          state_nxt = ST_DIS;
      end
      ST_DIS:
      begin
        oc_cnt_nxt   = EVT_RESET;
        bov_cnt_nxt  = EVT_RESET;
        ovp_seen_nxt = 1'b0;
        oc_trip_nxt  = 1'b0;
        if (!dis)
        begin
          state_nxt = ST_PROT;
          tmr_nxt   = '0;
        end
      end
      default:
      begin
        state_nxt = ST_DOWN;
      end
    endcase
  end

  // ****************************************
  // gate ramp
  // ****************************************
  always_comb
  begin
    gate_nxt = gate_r;
    if (fast_off)
      gate_nxt = GATE_OFF;
    else if (want_on && gate_r != GATE_FULL && gate_step)
      gate_nxt = gate_r + 1'b1;
    else if (soft_off && gate_r != GATE_OFF && gate_step)
      gate_nxt = gate_r - 1'b1;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r <= ST_DOWN;
      tmr_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  // event counters, cleared by power cycle
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      oc_cnt_r  <= EVT_RESET;
      bov_cnt_r <= EVT_RESET;
    end
    else
    begin
      oc_cnt_r  <= oc_cnt_nxt;
      bov_cnt_r <= bov_cnt_nxt;
    end
  end

  // fault memory flags
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bov_prev_r <= 1'b0;
      ovp_seen_r <= 1'b0;
      oc_trip_r  <= 1'b0;
    end
    else
    begin
      bov_prev_r <= bov;
      ovp_seen_r <= ovp_seen_nxt;
      oc_trip_r  <= oc_trip_nxt;
    end
  end

  // gate ramp, ramp prescaler and pin drivers
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      gate_r     <= GATE_OFF;
      ramp_div_r <= 2'b00;
      alert_r    <= 1'b0;
      cl_r       <= 1'b0;
    end
    else
    begin
      gate_r     <= gate_nxt;
      ramp_div_r <= ramp_div_r + 2'b01;
      alert_r    <= alert_nxt;
      cl_r       <= (state_nxt == ST_BLANK);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_pass_switch_on   = (gate_r != GATE_OFF);
  assign o_pass_switch_gate = gate_r;
  assign o_soft_start       = want_on && (gate_r != GATE_FULL);
  assign o_soft_stop        = soft_off && (gate_r != GATE_OFF);
  assign o_current_limit    = cl_r;
  assign o_alert_n_out      = 1'b0;
  assign o_alert_n_oe       = !alert_r;
  assign o_oc_count         = oc_cnt_r;
  assign o_bov_count        = bov_cnt_r;
endmodule
`default_nettype wire

// ### verif/prot_props.sv
// checker for the protection sequencer, port level only
// assumes binding onto charger_input_protection_fsm, one clock domain
`timescale 1ns/1ps
`default_nettype none
module prot_props
  import prot_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rstn,
  input wire logic              i_input_overvolt,
  input wire logic              i_overcurrent,
  input wire logic              i_battery_overvolt,
  input wire logic              i_overtemp,
  input wire logic              i_chip_en_n,
  input wire logic              o_pass_switch_on,
  input wire logic [GATE_W-1:0] o_pass_switch_gate,
  input wire logic              o_soft_start,
  input wire logic              o_soft_stop,
  input wire logic              o_current_limit,
  input wire logic              o_alert_n_out,
  input wire logic              o_alert_n_oe,
  input wire logic [EVT_W-1:0]  o_oc_count,
  input wire logic [EVT_W-1:0]  o_bov_count
);
  //****************************************
  // cycles since reset release
  //****************************************
  logic [10:0] age_r;
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      age_r <= '0;
    else if (age_r != 11'h7FF)
      age_r <= age_r + 11'h001;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  //****************************************
  // properties
  //****************************************
  property p_settle;
    age_r < 11'd990 |-> !o_pass_switch_on;
  endproperty
  a_settle: assert property (p_settle) else $error("switch on during settle");
  property p_ovp;
    $rose(i_input_overvolt) |-> ##[1:5] o_pass_switch_gate == GATE_OFF;
  endproperty
  a_ovp: assert property (p_ovp) else $error("slow overvolt turn off");
  property p_alert;
    $rose(i_overtemp) && !i_chip_en_n |-> ##[1:6] !o_alert_n_oe;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven");
  property p_dis_off;
    i_chip_en_n [*6] |-> o_pass_switch_gate == GATE_OFF && o_alert_n_oe;
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("disabled but active");
  property p_od;
    o_alert_n_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("alert drives high");
  property p_ramp;
    $rose(o_pass_switch_on) |-> o_pass_switch_gate == 8'h01 && o_soft_start;
  endproperty
  a_ramp: assert property (p_ramp) else $error("switch closed abruptly");
  property p_oc_step;
    o_oc_count != $past(o_oc_count) |-> o_oc_count == $past(o_oc_count) + 4'h1
      || o_oc_count == 4'h0;
  endproperty
  a_oc_step: assert property (p_oc_step) else $error("overcurrent count jump");
  property p_bov_lock;
    o_bov_count == EVT_LIMIT |-> !$rose(o_pass_switch_on);
  endproperty
  a_bov_lock: assert property (p_bov_lock) else $error("switch on while locked");
  c_on: cover property ($rose(o_pass_switch_on));
  c_lock: cover property (o_bov_count == EVT_LIMIT);
  c_lim: cover property ($rose(o_current_limit));
endmodule
bind charger_input_protection_fsm prot_props u_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_input_overvolt(i_input_overvolt),
  .i_overcurrent(i_overcurrent), .i_battery_overvolt(i_battery_overvolt),
  .i_overtemp(i_overtemp), .i_chip_en_n(i_chip_en_n),
  .o_pass_switch_on(o_pass_switch_on), .o_pass_switch_gate(o_pass_switch_gate),
  .o_soft_start(o_soft_start), .o_soft_stop(o_soft_stop),
  .o_current_limit(o_current_limit), .o_alert_n_out(o_alert_n_out),
  .o_alert_n_oe(o_alert_n_oe), .o_oc_count(o_oc_count), .o_bov_count(o_bov_count)
);
`default_nettype wire

// ### verif/host_side_model.sv
// host pin side: enable pull-down and alert pull-up
// assumes host drives enable only when i_drive is high
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
  input  wire logic i_drive,
  input  wire logic i_level,
  input  wire logic i_alert_n_out,
  input  wire logic i_alert_n_oe,
  output logic      o_chip_en_n,
  output logic      o_alert_line
);
  assign o_chip_en_n  = i_drive ? i_level : 1'b0;
  assign o_alert_line = i_alert_n_oe ? 1'b1 : i_alert_n_out;
endmodule
`default_nettype wire

// ### verif/charger_input_protection_fsm_bench.sv
// self-checking bench for the protection sequencer
// assumes a 100 MHz clock and package timer defaults
`timescale 1ns/1ps
`default_nettype none
module charger_input_protection_fsm_bench;
  import prot_pkg::*;
  logic clk, rstn, ovp, oc, bov, otp, drv, lvl, en_n, on, ss, sp, lim, aout, aoe, line;
  logic [7:0] gate;
  logic [3:0] occ, bvc;
  int err_total, checks, exp_oc, exp_bov;
  integer seed;
  charger_input_protection_fsm dut (.i_clk(clk), .i_rstn(rstn), .i_input_overvolt(ovp),
    .i_overcurrent(oc), .i_battery_overvolt(bov), .i_overtemp(otp), .i_chip_en_n(en_n),
    .o_pass_switch_on(on), .o_pass_switch_gate(gate), .o_soft_start(ss),
    .o_soft_stop(sp), .o_current_limit(lim), .o_alert_n_out(aout),
    .o_alert_n_oe(aoe), .o_oc_count(occ), .o_bov_count(bvc));
  host_side_model host (.i_drive(drv), .i_level(lvl), .i_alert_n_out(aout),
    .i_alert_n_oe(aoe), .o_chip_en_n(en_n), .o_alert_line(line));
  always #5 clk = ~clk;
  //****************************************
  // tasks
  //****************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_on(input logic v);
    int n;
    n = 0;
    while (on !== v && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk("switch", {7'h00, on}, {7'h00, v});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #900000;
    err_total++;
    complete_run();
  end
  //****************************************
  // main sequence
  //****************************************
  initial
  begin
    seed = 32'h8474ED0A;
    {clk, rstn, ovp, oc, bov, otp, lvl} = '0;
    drv = 1'b1;
    cyc(5);
    chk("gate", gate, GATE_OFF);
    chk("alert", {7'h00, line}, 8'h01);
    chk("count", {occ, bvc}, 8'h00);
    rstn = 1'b1;
    cyc(900);
    chk("switch", {7'h00, on}, 8'h00);
    wait_on(1'b1);
    chk("ramp", {7'h00, ss}, 8'h01);
    for (int f = 0; f < 2; f++)
    begin
      cyc(($random(seed) & 63) + 1);
      ovp = (f == 0);
      otp = (f == 1);
      cyc(5);
      chk("gate", gate, GATE_OFF);
      chk("alert", {7'h00, line}, 8'h00);
      {ovp, otp} = 2'b00;
      cyc(f ? 10 : 900);
      chk("switch", {7'h00, on}, {7'h00, f[0]});
      wait_on(1'b1);
    end
    {ovp, otp} = 2'b11;
    cyc(5);
    ovp = 1'b0;
    cyc(1100);
    chk("switch", {7'h00, on}, 8'h00);
    otp = 1'b0;
    wait_on(1'b1);
    {lvl, ovp} = 2'b11;
    cyc(6);
    chk("gate", gate, GATE_OFF);
    chk("alert", {7'h00, line}, 8'h01);
    {lvl, ovp} = 2'b00;
    wait_on(1'b1);
    drv = 1'b0;
    cyc(20);
    chk("switch", {7'h00, on}, 8'h01);
    oc = 1'b1;
    cyc(100);
    chk("limit", {7'h00, lim}, 8'h01);
    oc = 1'b0;
    cyc(1100);
    chk("count", {occ, on}, {4'h0, 4'h1});
    oc = 1'b1;
    exp_oc = 1;
    cyc(510);
    chk("count", {4'h0, occ}, exp_oc[7:0]);
    chk("stop", {7'h00, sp}, 8'h01);
    chk("alert", {7'h00, line}, 8'h00);
    oc = 1'b0;
    cyc(1500);
    chk("switch", {7'h00, on}, 8'h00);
    wait_on(1'b1);
    oc = 1'b1;
    for (int i = 2; i <= 15; i++)
    begin
      exp_oc = i;
      for (int n = 0; n < 3000 && occ !== exp_oc[3:0]; n++)
        cyc(1);
      chk("count", {4'h0, occ}, exp_oc[7:0]);
    end
    oc = 1'b0;
    cyc(2600);
    chk("switch", {7'h00, on}, 8'h00);
    chk("alert", {7'h00, line}, 8'h00);
    rstn = 1'b0;
    ovp = 1'b1;
    exp_oc = 0;
    cyc(2);
    chk("count", {4'h0, occ}, exp_oc[7:0]);
    rstn = 1'b1;
    cyc(1100);
    chk("switch", {7'h00, on}, 8'h00);
    chk("alert", {7'h00, line}, 8'h00);
    ovp = 1'b0;
    wait_on(1'b1);
    cyc(300);
    for (int i = 1; i <= 15; i++)
    begin
      bov = 1'b1;
      exp_bov = i;
      cyc(6);
      if (i == 1)
        chk("stop", {7'h00, sp}, 8'h01);
      chk("alert", {7'h00, line}, 8'h00);
      chk("count", {4'h0, bvc}, exp_bov[7:0]);
      wait_on(1'b0);
      bov = 1'b0;
      if (i < 15)
        wait_on(1'b1);
    end
    cyc(300);
    chk("switch", {7'h00, on}, 8'h00);
    {drv, lvl} = 2'b11;
    cyc(6);
    lvl = 1'b0;
    exp_bov = 0;
    cyc(6);
    chk("count", {4'h0, bvc}, exp_bov[7:0]);
    wait_on(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
